//--- common/frame_seq_pkg.sv
// Constants shared by the frame sequencer and its pin filter.
// Assumes a 200 MHz system clock; device timing is given in 25 ns ticks.
package frame_seq_pkg;

	// Clock relation
	localparam int CLK_NS = 5;
	localparam int DEV_CLK_NS = 25;
	localparam int DEV_TO_CLK = DEV_CLK_NS / CLK_NS;

	// Sub-frame timing in device ticks
	localparam int SUBFRAME_DEV_CLKS = 10000;
	localparam int INTEG_DEV_CLKS = 8192;
	localparam int SUBFRAME_CYCLES = SUBFRAME_DEV_CLKS * DEV_TO_CLK;
	localparam int INTEG_CYCLES = INTEG_DEV_CLKS * DEV_TO_CLK;

	// Wake-up delay = (WAKE_MULT * field + WAKE_ADD) device ticks
	localparam int WAKE_MULT_SHIFT = 6;
	localparam int WAKE_ADD = 2;
	localparam int WAKE_W = 24;

	// Pin pulse windows
	localparam int TRIG_MIN_NS = 100;
	localparam int TRIG_MAX_NS = 1000;
	localparam int RESET_MIN_NS = 30000;
	localparam int TRIG_MIN_CYCLES = (TRIG_MIN_NS + CLK_NS - 1) / CLK_NS;
	localparam int TRIG_MAX_CYCLES = TRIG_MAX_NS / CLK_NS;
	localparam int RESET_MIN_CYCLES = (RESET_MIN_NS + CLK_NS - 1) / CLK_NS;

	// Register offsets
	localparam logic [7:0] ADDR_CAPTURE = 8'h00;
	localparam logic [7:0] ADDR_AMPLITUDE = 8'h01;
	localparam logic [7:0] ADDR_WAKEUP = 8'h26;
	localparam logic [7:0] ADDR_RUN_MODE = 8'h27;
	localparam logic [7:0] ADDR_FRAME_LEN = 8'h9f;

	// Field positions
	localparam int TRIG_BIT = 23;
	localparam int BUSY_BIT = 1;
	localparam int WAKING_BIT = 0;
	localparam int WAKE_LSB = 10;
	localparam int WAKE_MSB = 23;
	localparam int MODE_LSB = 0;
	localparam int MODE_MSB = 1;
	localparam int FRAMES_LSB = 2;
	localparam int FRAMES_MSB = 7;
	localparam int SUBCNT_LSB = 0;
	localparam int SUBCNT_MSB = 11;
	localparam int AVG_LSB = 12;
	localparam int AVG_MSB = 23;

	// Mode codes
	localparam logic [1:0] MODE_CONTINUOUS = 2'h0;
	localparam logic [1:0] MODE_SINGLE_SHOT = 2'h3;

	// Reset values
	localparam logic [1:0] MODE_RESET = 2'h0;
	localparam logic [5:0] FRAMES_RESET = 6'h00;
	localparam logic [13:0] WAKE_RESET = 14'h0000;
	localparam logic [11:0] SUBCNT_RESET = 12'h000;
	localparam logic [11:0] AVG_RESET = 12'h000;

	typedef enum logic [2:0] {
		ST_SLEEP = 3'b001,
		ST_WAKE = 3'b010,
		ST_RUN = 3'b100
	} seq_state_type;

endpackage : frame_seq_pkg

//--- hw/frame_sequencer.sv
// Frame timing sequencer for a time-of-flight front end.
// Assumes a register port driven by an external serial slave, synchronous pin
// input and one amplitude sample from the depth engine per sub-frame.
// How it works
// - Two-bit mode: 0 continuous, 3 single-shot
// - Continuous mode runs frames back to back
// - Single-shot sleeps until pin or register trigger
// - Trigger: wake, wait delay, capture frames, sleep
// - Triggers during a capture are ignored
// - Start delay is 64 times field plus 2 ticks
// - Long low pulse resets, short one of 100 to 1000 ns triggers
// - Trigger bit self-clears after last sample
// - Frame holds sub-frame field plus one sub-frames
// - Sub-frame lasts 10000 device clock ticks
// - First 8192 ticks integrate, rest process
// - Sample rate is 4000 over field plus one
// - Average field plus one sub-frames per frame
// - Non power-of-two averages scale amplitude down
// - Fixed illumination for every sub-frame
`timescale 1ns/1ps
module frame_sequencer #(
	parameter int SUBFRAME_CYCLES = frame_seq_pkg::SUBFRAME_CYCLES,
	parameter int INTEG_CYCLES = frame_seq_pkg::INTEG_CYCLES,
	parameter int RESET_MIN = frame_seq_pkg::RESET_MIN_CYCLES,
	parameter int AMP_W = 16
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// Reset/trigger pin
	input wire logic reset_trigger_pin_n_i,
	// Register port
	input wire logic [7:0] reg_addr_i,
	input wire logic [23:0] reg_wdata_i,
	input wire logic reg_we_i,
	input wire logic reg_re_i,
	output logic [23:0] reg_rdata_o,
	// Depth engine
	input wire logic [AMP_W-1:0] amp_sample_i,
	output logic [AMP_W-1:0] amplitude_result_o,
	// Sequencing
	output logic frame_start_strobe_o,
	output logic frame_valid_strobe_o,
	output logic integrate_o,
	output logic illum_on_o,
	output logic deep_sleep_o
);
	localparam int CW = $clog2(SUBFRAME_CYCLES);
	localparam int ACC_W = AMP_W + 12;
	localparam int WW = frame_seq_pkg::WAKE_W;

	// Wake-up delay in system clocks, less the two cycles of pipeline
	function automatic logic [WW-1:0] wake_wait(input logic [13:0] field);
		logic [WW-1:0] ticks;
		ticks = {4'h0, field, 6'h00} + WW'(frame_seq_pkg::WAKE_ADD);
		return WW'(ticks * WW'(frame_seq_pkg::DEV_TO_CLK)) - WW'(2);
	endfunction : wake_wait

	// Ceiling of log2 for a count from 1 to 4096
	function automatic logic [3:0] ceil_log2(input logic [12:0] n);
		logic [3:0] r;
		r = 4'h0;
		for (int i = 0; i < 13; i++) begin
			if ((13'(1) << i) < n) begin
				r = 4'(i + 1);
			end
		end
		return r;
	endfunction : ceil_log2

	frame_seq_pkg::seq_state_type state_q, state_d;
	logic [1:0] mode_q, mode_d;
	logic [5:0] frames_q, frames_d;
	logic [13:0] wake_q, wake_d;
	logic [11:0] subcnt_q, subcnt_d;
	logic [11:0] avg_q, avg_d;
	logic trig_bit_q, trig_bit_d;
	logic [CW-1:0] cyc_q, cyc_d;
	logic [WW-1:0] wait_q, wait_d;
	logic [11:0] sub_idx_q, sub_idx_d;
	logic [5:0] left_q, left_d;
	logic [ACC_W-1:0] acc_q, acc_d;
	logic [AMP_W-1:0] amp_q, amp_d;
	logic [23:0] rdata_q, rdata_d;
	logic fstart_q, fstart_d;
	logic fvalid_q, fvalid_d;
	logic integ_q, integ_d;
	logic pin_trig;
	logic pin_reset;
	logic [ACC_W-1:0] acc_sum;
	logic [3:0] shift;

	pin_pulse_filter #(
		.TRIG_MIN(frame_seq_pkg::TRIG_MIN_CYCLES),
		.TRIG_MAX(frame_seq_pkg::TRIG_MAX_CYCLES),
		.RESET_MIN(RESET_MIN)
	) u_pin_filter (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.pin_n_i(reset_trigger_pin_n_i),
		.trigger_o(pin_trig),
		.reset_req_o(pin_reset)
	);

	// Sum including the sample of this sub-frame when it is averaged
	always_comb begin
		acc_sum = acc_q;
		if (sub_idx_q <= avg_q) begin
			acc_sum = acc_q + ACC_W'(amp_sample_i);
		end
		shift = ceil_log2({1'b0, avg_q} + 13'h1);
	end

	always_comb begin
		state_d = state_q;
		mode_d = mode_q;
		frames_d = frames_q;
		wake_d = wake_q;
		subcnt_d = subcnt_q;
		avg_d = avg_q;
		trig_bit_d = trig_bit_q;
		cyc_d = cyc_q;
		wait_d = wait_q;
		sub_idx_d = sub_idx_q;
		left_d = left_q;
		acc_d = acc_q;
		amp_d = amp_q;
		rdata_d = 24'h000000;
		fstart_d = 1'b0;
		fvalid_d = 1'b0;

		// Register writes
		if (reg_we_i) begin
			if (reg_addr_i == frame_seq_pkg::ADDR_CAPTURE) begin
				// Accepted only while asleep in single-shot mode
				if (reg_wdata_i[frame_seq_pkg::TRIG_BIT] &&
						state_q == frame_seq_pkg::ST_SLEEP &&
						mode_q == frame_seq_pkg::MODE_SINGLE_SHOT) begin
					trig_bit_d = 1'b1;
				end
			end else if (reg_addr_i == frame_seq_pkg::ADDR_WAKEUP) begin
				wake_d = reg_wdata_i[frame_seq_pkg::WAKE_MSB:frame_seq_pkg::WAKE_LSB];
			end else if (reg_addr_i == frame_seq_pkg::ADDR_RUN_MODE) begin
				mode_d = reg_wdata_i[frame_seq_pkg::MODE_MSB:frame_seq_pkg::MODE_LSB];
				frames_d = reg_wdata_i[frame_seq_pkg::FRAMES_MSB:frame_seq_pkg::FRAMES_LSB];
			end else if (reg_addr_i == frame_seq_pkg::ADDR_FRAME_LEN) begin
				subcnt_d = reg_wdata_i[frame_seq_pkg::SUBCNT_MSB:frame_seq_pkg::SUBCNT_LSB];
				avg_d = reg_wdata_i[frame_seq_pkg::AVG_MSB:frame_seq_pkg::AVG_LSB];
			end
		end

		// Register reads
		if (reg_re_i) begin
			if (reg_addr_i == frame_seq_pkg::ADDR_CAPTURE) begin
				rdata_d[frame_seq_pkg::TRIG_BIT] = trig_bit_q;
				rdata_d[frame_seq_pkg::BUSY_BIT] = (state_q != frame_seq_pkg::ST_SLEEP);
				rdata_d[frame_seq_pkg::WAKING_BIT] = (state_q == frame_seq_pkg::ST_WAKE);
			end else if (reg_addr_i == frame_seq_pkg::ADDR_AMPLITUDE) begin
				rdata_d[AMP_W-1:0] = amp_q;
			end else if (reg_addr_i == frame_seq_pkg::ADDR_WAKEUP) begin
				rdata_d[frame_seq_pkg::WAKE_MSB:frame_seq_pkg::WAKE_LSB] = wake_q;
			end else if (reg_addr_i == frame_seq_pkg::ADDR_RUN_MODE) begin
				rdata_d[frame_seq_pkg::MODE_MSB:frame_seq_pkg::MODE_LSB] = mode_q;
				rdata_d[frame_seq_pkg::FRAMES_MSB:frame_seq_pkg::FRAMES_LSB] = frames_q;
			end else if (reg_addr_i == frame_seq_pkg::ADDR_FRAME_LEN) begin
				rdata_d[frame_seq_pkg::SUBCNT_MSB:frame_seq_pkg::SUBCNT_LSB] = subcnt_q;
				rdata_d[frame_seq_pkg::AVG_MSB:frame_seq_pkg::AVG_LSB] = avg_q;
			end
		end

		case (state_q)
			frame_seq_pkg::ST_SLEEP: begin
				if (mode_q == frame_seq_pkg::MODE_CONTINUOUS) begin
					state_d = frame_seq_pkg::ST_RUN;
					cyc_d = '0;
					sub_idx_d = 12'h000;
					acc_d = '0;
					fstart_d = 1'b1;
				end else if (mode_q == frame_seq_pkg::MODE_SINGLE_SHOT &&
						(pin_trig || trig_bit_q)) begin
					state_d = frame_seq_pkg::ST_WAKE;
					wait_d = wake_wait(wake_q);
				end
			end
			frame_seq_pkg::ST_WAKE: begin
				if (wait_q == '0) begin
					state_d = frame_seq_pkg::ST_RUN;
					cyc_d = '0;
					sub_idx_d = 12'h000;
					acc_d = '0;
					fstart_d = 1'b1;
					// A zero frame count still captures one frame
					left_d = (frames_q == 6'h00) ? 6'h01 : frames_q;
				end else begin
					wait_d = wait_q - WW'(1);
				end
			end
			frame_seq_pkg::ST_RUN: begin
				if (cyc_q == CW'(SUBFRAME_CYCLES - 1)) begin
					cyc_d = '0;
					acc_d = acc_sum;
					if (sub_idx_q == subcnt_q) begin
						// Shift by ceil(log2(N+1)) gives the (N+1)/2^k scaling
						amp_d = AMP_W'(acc_sum >> shift);
						fvalid_d = 1'b1;
						sub_idx_d = 12'h000;
						acc_d = '0;
						if (mode_q == frame_seq_pkg::MODE_CONTINUOUS) begin
							fstart_d = 1'b1;
						end else if (mode_q == frame_seq_pkg::MODE_SINGLE_SHOT &&
								left_q > 6'h01) begin
							left_d = left_q - 6'h01;
							fstart_d = 1'b1;
						end else begin
							state_d = frame_seq_pkg::ST_SLEEP;
							trig_bit_d = 1'b0;
							left_d = 6'h00;
						end
					end else begin
						sub_idx_d = sub_idx_q + 12'h001;
					end
				end else begin
					cyc_d = cyc_q + CW'(1);
				end
			end
			default: begin
				state_d = frame_seq_pkg::ST_SLEEP;
			end
		endcase

		// Pin reset returns everything except read data to its reset value
		if (pin_reset) begin
			state_d = frame_seq_pkg::ST_SLEEP;
			mode_d = frame_seq_pkg::MODE_RESET;
			frames_d = frame_seq_pkg::FRAMES_RESET;
			wake_d = frame_seq_pkg::WAKE_RESET;
			subcnt_d = frame_seq_pkg::SUBCNT_RESET;
			avg_d = frame_seq_pkg::AVG_RESET;
			trig_bit_d = 1'b0;
			cyc_d = '0;
			wait_d = '0;
			sub_idx_d = 12'h000;
			left_d = 6'h00;
			acc_d = '0;
			amp_d = '0;
			fstart_d = 1'b0;
			fvalid_d = 1'b0;
		end

		integ_d = (state_d == frame_seq_pkg::ST_RUN) && (cyc_d < CW'(INTEG_CYCLES));
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_q <= frame_seq_pkg::ST_SLEEP;
			mode_q <= frame_seq_pkg::MODE_RESET;
			frames_q <= frame_seq_pkg::FRAMES_RESET;
			wake_q <= frame_seq_pkg::WAKE_RESET;
			subcnt_q <= frame_seq_pkg::SUBCNT_RESET;
			avg_q <= frame_seq_pkg::AVG_RESET;
			trig_bit_q <= 1'b0;
			cyc_q <= '0;
			wait_q <= '0;
			sub_idx_q <= 12'h000;
			left_q <= 6'h00;
			acc_q <= '0;
			amp_q <= '0;
			rdata_q <= 24'h000000;
			fstart_q <= 1'b0;
			fvalid_q <= 1'b0;
			integ_q <= 1'b0;
		end else begin
			state_q <= state_d;
			mode_q <= mode_d;
			frames_q <= frames_d;
			wake_q <= wake_d;
			subcnt_q <= subcnt_d;
			avg_q <= avg_d;
			trig_bit_q <= trig_bit_d;
			cyc_q <= cyc_d;
			wait_q <= wait_d;
			sub_idx_q <= sub_idx_d;
			left_q <= left_d;
			acc_q <= acc_d;
			amp_q <= amp_d;
			rdata_q <= rdata_d;
			fstart_q <= fstart_d;
			fvalid_q <= fvalid_d;
			integ_q <= integ_d;
		end
	end

	assign reg_rdata_o = rdata_q;
	assign amplitude_result_o = amp_q;
	assign frame_start_strobe_o = fstart_q;
	assign frame_valid_strobe_o = fvalid_q;
	assign integrate_o = integ_q;
	// One fixed drive level, lit during every integration window
	assign illum_on_o = integ_q;
	assign deep_sleep_o = (state_q == frame_seq_pkg::ST_SLEEP);

endmodule : frame_sequencer

//--- hw/pin_pulse_filter.sv
// Classifies low pulses on the reset/trigger pin by their length.
// Assumes the pin is already synchronous to clk_i.
`timescale 1ns/1ps
module pin_pulse_filter #(
	parameter int TRIG_MIN = frame_seq_pkg::TRIG_MIN_CYCLES,
	parameter int TRIG_MAX = frame_seq_pkg::TRIG_MAX_CYCLES,
	parameter int RESET_MIN = frame_seq_pkg::RESET_MIN_CYCLES
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// Pin
	input wire logic pin_n_i,
	// Classified events
	output logic trigger_o,
	output logic reset_req_o
);
	localparam int CW = $clog2(RESET_MIN + 1);

	logic [CW-1:0] low_cnt_q, low_cnt_d;
	logic trig_q, trig_d;
	logic rst_q, rst_d;

	always_comb begin
		low_cnt_d = low_cnt_q;
		trig_d = 1'b0;
		rst_d = 1'b0;
		if (!pin_n_i) begin
			if (low_cnt_q != CW'(RESET_MIN)) begin
				low_cnt_d = low_cnt_q + CW'(1);
			end
			// Reset fires once while the pin is still held low
			if (low_cnt_q == CW'(RESET_MIN - 1)) begin
				rst_d = 1'b1;
			end
		end else begin
			// Trigger only for a pulse inside the window; others are dropped
			if (low_cnt_q >= CW'(TRIG_MIN) && low_cnt_q <= CW'(TRIG_MAX)) begin
				trig_d = 1'b1;
			end
			low_cnt_d = '0;
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			low_cnt_q <= '0;
			trig_q <= 1'b0;
			rst_q <= 1'b0;
		end else begin
			low_cnt_q <= low_cnt_d;
			trig_q <= trig_d;
			rst_q <= rst_d;
		end
	end

	assign trigger_o = trig_q;
	assign reset_req_o = rst_q;

endmodule : pin_pulse_filter

//--- sim/frame_sequencer_bench.sv
// Self-checking bench for the frame sequencer with a host model.
// Short sub-frames; the checker is bound in from its own file.
`timescale 1ns/1ps
module frame_sequencer_bench;
	localparam int SUB = 100;
	localparam int INTEG = 60;
	logic clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic [15:0] amp_sample_i = 16'h0000;
	logic [7:0] reg_addr_i;
	logic [23:0] reg_wdata_i, reg_rdata_o, rdv, wv;
	logic reg_we_i, reg_re_i, pin_n_i, fs, fv, sleep, integ, illum;
	logic [15:0] amplitude_result_o;
	logic [31:0] seed = 32'h00014345;
	logic [7:0] addrs[4] = '{8'h26, 8'h27, 8'h9f, 8'h55};
	logic [23:0] cfg[2] = '{24'h002002, 24'h001003};
	int err_total = 0;
	int n_compared = 0;
	int n;
	always #2.5 clk_i = ~clk_i;
	reg_host i_host (.clk_i(clk_i), .reg_rdata_i(reg_rdata_o), .reg_addr_o(reg_addr_i),
		.reg_wdata_o(reg_wdata_i), .reg_we_o(reg_we_i), .reg_re_o(reg_re_i), .pin_n_o(pin_n_i));
	frame_sequencer #(.SUBFRAME_CYCLES(SUB), .INTEG_CYCLES(INTEG), .RESET_MIN(300)) i_dut (
		.clk_i(clk_i), .rstn_i(rstn_i), .reset_trigger_pin_n_i(pin_n_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i),
		.reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o), .amp_sample_i(amp_sample_i),
		.amplitude_result_o(amplitude_result_o), .frame_start_strobe_o(fs),
		.frame_valid_strobe_o(fv), .integrate_o(integ), .illum_on_o(illum),
		.deep_sleep_o(sleep));
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs
	function automatic logic [23:0] rmask(input logic [7:0] a);
		case (a)
			frame_seq_pkg::ADDR_WAKEUP: return 24'hfffc00;
			frame_seq_pkg::ADDR_RUN_MODE: return 24'h0000ff;
			frame_seq_pkg::ADDR_FRAME_LEN: return 24'hffffff;
			default: return 24'h000000;
		endcase
	endfunction : rmask
	function automatic logic [15:0] amp_exp(input logic [15:0] v, input int avg);
		logic [31:0] s;
		s = {16'h0000, v} * (avg + 1);
		return 16'(s >> $clog2(avg + 1));
	endfunction : amp_exp
	task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
		n_compared++;
		if (got !== exp) begin
			$display("[ERR] %s expected %h seen %h", what, exp, got);
			err_total++;
		end
	endtask : chk
	task automatic rchk(input logic [7:0] a, input logic [23:0] exp);
		i_host.rd(a, rdv);
		chk("read data", exp, rdv);
	endtask : rchk
	task automatic wait_fs(output int c);
		c = 0;
		do begin
			@(negedge clk_i);
			c++;
		end while (fs !== 1'b1 && c < 90000);
	endtask : wait_fs
	// Frame starts seen until deep sleep returns
	task automatic count_run(output int c);
		int t;
		c = 0;
		for (t = 0; t < 20000 && sleep !== 1'b1; t++) begin
			@(negedge clk_i);
			if (fs === 1'b1) c++;
		end
		chk("deep sleep reached", 24'h000001, {23'h0, sleep});
	endtask : count_run
	task automatic summarize();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : summarize
	initial begin
		#(95000 * 5);
		err_total++;
		summarize();
	end
	initial begin
		repeat (3) @(negedge clk_i);
		rstn_i = 1'b1;
		foreach (addrs[i]) rchk(addrs[i], 24'h000000);
		i_host.wr(frame_seq_pkg::ADDR_RUN_MODE, 24'h000003);
		count_run(n);
		chk("asleep in mode 3", 24'h000001, {23'h0, sleep});
		rchk(frame_seq_pkg::ADDR_CAPTURE, 24'h000000);
		for (int k = 0; k < 12; k++) begin
			seed = xs(seed);
			wv = seed[23:0];
			if (k % 4 == 1 && wv[1:0] == 2'h0) wv[1:0] = 2'h3;
			i_host.wr(addrs[k % 4], wv);
			rchk(addrs[k % 4], wv & rmask(addrs[k % 4]));
		end
		i_host.pulse(310);
		repeat (5) @(negedge clk_i);
		rchk(frame_seq_pkg::ADDR_RUN_MODE, 24'h000000);
		rchk(frame_seq_pkg::ADDR_FRAME_LEN, 24'h000000);
		$display("test registers and pin reset done");
		for (int k = 0; k < 2; k++) begin
			seed = xs(seed);
			amp_sample_i = seed[15:0];
			i_host.wr(frame_seq_pkg::ADDR_FRAME_LEN, cfg[k]);
			wait_fs(n);
			wait_fs(n);
			chk("frame length", 24'(SUB * (cfg[k][11:0] + 1)), 24'(n));
			chk("frame valid", 24'h000001, {23'h0, fv});
			chk("amplitude", {8'h00, amp_exp(amp_sample_i, int'(cfg[k][23:12]))},
				{8'h00, amplitude_result_o});
			// Lit integration cycles across one sub-frame from frame start
			n = 0;
			repeat (SUB) begin
				if (integ === 1'b1 && illum === 1'b1) n++;
				@(negedge clk_i);
			end
			chk("integrate cycles", 24'(INTEG), 24'(n));
		end
		$display("test continuous frames done");
		// Smallest wake-up delay that still covers 0.4 ms
		i_host.wr(frame_seq_pkg::ADDR_WAKEUP, 24'h03e800);
		i_host.wr(frame_seq_pkg::ADDR_RUN_MODE, 24'h00000b);
		count_run(n);
		i_host.pulse(50);
		wait_fs(n);
		chk("pin trigger delay", 24'(5 * (64 * 250 + 2) + 1), 24'(n));
		i_host.pulse(50);
		count_run(n);
		chk("frames after trigger", 24'h000001, 24'(n));
		$display("test pin trigger done");
		i_host.pulse(19);
		i_host.pulse(201);
		n = 0;
		repeat (400) begin
			@(negedge clk_i);
			if (sleep !== 1'b1) n++;
		end
		chk("awake cycles", 24'h000000, 24'(n));
		$display("test ignored pulses done");
		i_host.wr(frame_seq_pkg::ADDR_WAKEUP, 24'h000000);
		i_host.wr(frame_seq_pkg::ADDR_RUN_MODE, 24'h000003);
		i_host.wr(frame_seq_pkg::ADDR_CAPTURE, 24'h800000);
		wait_fs(n);
		chk("register trigger delay", 24'(5 * 2), 24'(n));
		i_host.rd(frame_seq_pkg::ADDR_CAPTURE, rdv);
		chk("trigger bit", 24'h000001, {23'h0, rdv[23]});
		count_run(n);
		chk("extra frames", 24'h000000, 24'(n));
		rchk(frame_seq_pkg::ADDR_CAPTURE, 24'h000000);
		$display("test register trigger done");
		summarize();
	end
endmodule : frame_sequencer_bench

//--- sim/frame_sequencer_chk.sv
// Concurrent checks on the frame sequencer outputs.
// Bound into frame_sequencer; sees its ports only.
`timescale 1ns/1ps
module frame_sequencer_chk #(
	parameter int SUBFRAME_CYCLES = 100,
	parameter int INTEG_CYCLES = 60
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic reg_re_i,
	input wire logic [23:0] reg_rdata_o,
	input wire logic frame_start_strobe_o,
	input wire logic frame_valid_strobe_o,
	input wire logic integrate_o,
	input wire logic illum_on_o,
	input wire logic deep_sleep_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	// Run lengths of integrate high and low
	logic [16:0] hi_q;
	logic [16:0] lo_q;
	logic slept_q;
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			hi_q <= 17'h00000;
			lo_q <= 17'h00000;
			slept_q <= 1'b1;
		end else begin
			hi_q <= integrate_o ? hi_q + 17'h00001 : 17'h00000;
			lo_q <= integrate_o ? 17'h00000 : lo_q + 17'h00001;
			slept_q <= deep_sleep_o | (slept_q & ~integrate_o);
		end
	end
	a_start_integ: assert property (frame_start_strobe_o |-> integrate_o && !deep_sleep_o)
		else $error("frame start outside integration");
	a_illum_fixed: assert property (illum_on_o == integrate_o)
		else $error("illumination differs from integration");
	a_sleep_quiet: assert property (deep_sleep_o |-> !integrate_o && !frame_start_strobe_o)
		else $error("activity while asleep");
	a_start_single: assert property (frame_start_strobe_o |=> !frame_start_strobe_o [*8])
		else $error("frame start strobe too long");
	a_valid_single: assert property (frame_valid_strobe_o |=> !frame_valid_strobe_o)
		else $error("frame valid strobe too long");
	a_valid_after_proc: assert property (frame_valid_strobe_o |-> !$past(integrate_o))
		else $error("result ready during integration");
	a_integ_len: assert property ($fell(integrate_o) |-> hi_q == INTEG_CYCLES)
		else $error("integration length wrong");
	a_subframe_gap: assert property ($rose(integrate_o) && !slept_q
		|-> lo_q == SUBFRAME_CYCLES - INTEG_CYCLES)
		else $error("sub-frame length wrong");
	a_rdata_idle: assert property (!reg_re_i |=> reg_rdata_o == 24'h000000)
		else $error("read data not cleared");
endmodule : frame_sequencer_chk

bind frame_sequencer frame_sequencer_chk #(
	.SUBFRAME_CYCLES(SUBFRAME_CYCLES),
	.INTEG_CYCLES(INTEG_CYCLES)
) i_chk (
	.clk_i(clk_i),
	.rstn_i(rstn_i),
	.reg_re_i(reg_re_i),
	.reg_rdata_o(reg_rdata_o),
	.frame_start_strobe_o(frame_start_strobe_o),
	.frame_valid_strobe_o(frame_valid_strobe_o),
	.integrate_o(integrate_o),
	.illum_on_o(illum_on_o),
	.deep_sleep_o(deep_sleep_o)
);

//--- sim/reg_host.sv
// Host model: register port master and reset/trigger pin driver.
// Drives on the falling clock edge; the pin idles high.
`timescale 1ns/1ps
module reg_host (
	// Clock and read data
	input wire logic clk_i,
	input wire logic [23:0] reg_rdata_i,
	// Register port
	output logic [7:0] reg_addr_o,
	output logic [23:0] reg_wdata_o,
	output logic reg_we_o,
	output logic reg_re_o,
	// Reset/trigger pin
	output logic pin_n_o
);
	initial begin
		reg_addr_o = 8'h00;
		reg_wdata_o = 24'h000000;
		reg_we_o = 1'b0;
		reg_re_o = 1'b0;
		pin_n_o = 1'b1;
	end
	// Released lines show the inverse, not the last value
	task automatic wr(input logic [7:0] a, input logic [23:0] d);
		@(negedge clk_i);
		reg_addr_o = a;
		reg_wdata_o = d;
		reg_we_o = 1'b1;
		@(negedge clk_i);
		reg_we_o = 1'b0;
		reg_addr_o = ~a;
		reg_wdata_o = ~d;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [23:0] d);
		@(negedge clk_i);
		reg_addr_o = a;
		reg_re_o = 1'b1;
		@(negedge clk_i);
		reg_re_o = 1'b0;
		reg_addr_o = ~a;
		d = reg_rdata_i;
	endtask : rd
	task automatic pulse(input int len);
		@(negedge clk_i);
		pin_n_o = 1'b0;
		repeat (len) @(negedge clk_i);
		pin_n_o = 1'b1;
	endtask : pulse
endmodule : reg_host
